//--- design/power_down_and_brownout_sequencer.sv
// Power-down and start-condition sequencer: sleep entry, warm/cold start, brown-out reset.
// Assumes instruction strobes on clock; pins and voltage comparator are asynchronous.
// Functional notes
// RL1: Voltage below threshold resets processor while detector is active.
// RL2: Once enabled, detection stays active in both sleep modes.
// RL3: Detector enable is one-shot; only system reset revokes it; the code also revokes it on the reset pin.
// RL4: Arm then first sleep instruction enters clock-operating mode.
// RL5: Arm then second sleep instruction enters RAM back-up mode.
// RL6: Sleep instruction without arming acts as no-operation.
// RL7: Clock-operating mode keeps RAM, reset, sub-clock, LCD, timer 3 alive.
// RL8: RAM back-up keeps only RAM and reset; LCD off, timer 3 undefined.
// RL9: Wakeup or timer 3 underflow restarts at zero with power flag 1.
// RL10: Reset pin, watchdog or voltage drop restarts with power flag 0.
// RL11: Software reads power flag and timer 3 flag to identify start.
// RL12: Sleep entry initializes PC, A, B, carry, SP, interrupt and timer controls.
// RL13: Sleep retains control, clock, timer, LCD, pull-up, wakeup, port registers.
// RL14: RAM back-up sets stack pointer to 7; others need re-initialization.
// RL15: Timers 1 and 2 and their flags are undefined after sleep.
// RL16: Sleep initializes watchdog; software restarts it before sleeping.
// RL17: RAM back-up drives carry/counter pin low, or floats it when select is 11.
// RL18: RAM back-up wakes only on external wakeup; clock mode also on timer 3.
// RL19: Sleep entered with timer 3 flag set returns immediately; the code does this in clock-operating mode only.
// RL20: Arming clears on any reset and on completed power-down entry.
`timescale 1ns/1ps

module power_down_and_brownout_sequencer
   import pwr_seq_pkg::*;
(
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               rst,
   // Instruction strobes
   input  wire pwr_seq_pkg::instr_t instr,
   // Asynchronous sources
   input  wire pwr_seq_pkg::pins_t pins,
   // Same-domain sources
   input  wire logic               watchdogReset,
   input  wire logic               timer3Flag,
   input  wire logic [1:0]         counterSelect,
   input  wire logic               carryOut,
   // Status to CPU
   output logic                    powerFlag,
   output logic                    detectorActive,
   output logic                    armed,
   output logic                    asleep,
   output logic                    cpuReset,
   output logic                    warmStart,
   output pwr_seq_pkg::ctrl_t      ctrl,
   // Carry/counter pin
   output logic                    carryPinOut,
   output logic                    carryPinOe
);
   import pwr_seq_pkg::*;

   pins_t      meta_r;
   pins_t      sync_r;
   pwr_state_t state_r;
   pwr_state_t state_nxt;
   logic       pflag_r;
   logic       pflag_nxt;
   logic       detEn_r;
   logic       arm_r;
   logic       arm_nxt;
   logic       cold_r;
   logic       warm_r;
   logic       pinOut_r;
   logic       pinOe_r;
   ctrl_t      ctrl_r;
   ctrl_t      ctrl_nxt;

   // Two-flop synchronisers; first stage feeds only the second
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= pins;
         sync_r <= meta_r;
      end
   end

   wire brownOut   = detEn_r & sync_r.voltageLow;                      // RL1 RL2
   wire coldEvent  = sync_r.resetPin | watchdogReset | brownOut;       // RL10
   wire enterClock = instr.clockRunSleep & arm_r & (state_r == ST_RUN); // RL4 RL6
   wire enterRam   = instr.ramBackupSleep & arm_r & (state_r == ST_RUN) & ~instr.clockRunSleep; // RL5 RL6
   wire clockWake  = sync_r.extWakeup | timer3Flag;                    // RL18 RL19
   wire ramWake    = sync_r.extWakeup;                                 // RL18
   wire floatPin   = (counterSelect == COUNTER_INPUT_INPUT_SEL);                // RL17

   always_comb begin
      state_nxt = state_r;
      pflag_nxt = pflag_r;
      arm_nxt   = arm_r;
      if (instr.sleepArm && state_r == ST_RUN) begin
         arm_nxt = 1'b1;
      end
      case (state_r)
         ST_RUN: begin
            if (enterClock) begin
               state_nxt = ST_CLOCK_RUN;                               // RL4
               arm_nxt   = 1'b0;                                       // RL20
            end else if (enterRam) begin
               state_nxt = ST_RAM_BACKUP;                              // RL5
               arm_nxt   = 1'b0;                                       // RL20
            end
         end
         ST_CLOCK_RUN: begin
            if (clockWake) begin
               state_nxt = ST_WAKE;                                    // RL9 RL19
               pflag_nxt = PFLAG_WARM;
            end
         end
         ST_RAM_BACKUP: begin
            if (ramWake) begin
               state_nxt = ST_WAKE;                                    // RL9 RL18
               pflag_nxt = PFLAG_WARM;
            end
         end
         ST_WAKE: begin
            state_nxt = ST_RUN;
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
      if (coldEvent) begin
         state_nxt = ST_RUN;                                           // RL10
         pflag_nxt = PFLAG_RESET;
         arm_nxt   = 1'b0;                                             // RL20
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r <= ST_RUN;
         pflag_r <= PFLAG_RESET;
         arm_r   <= 1'b0;
         cold_r  <= 1'b1;
         warm_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pflag_r <= pflag_nxt;
         arm_r   <= arm_nxt;
         cold_r  <= coldEvent;                                         // RL1 RL10
         warm_r  <= (state_r == ST_WAKE);                              // RL9
      end
   end

   // Detector enable: one-shot, cleared only by reset pin or power-on
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         detEn_r <= 1'b0;
      end else if (sync_r.resetPin) begin
         detEn_r <= 1'b0;                                              // RL3
      end else if (instr.detectorEnable) begin
         detEn_r <= 1'b1;                                              // RL3
      end
   end

   // Pin levels while in RAM back-up; registered so the pin never glitches
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pinOut_r <= 1'b0;
         pinOe_r  <= 1'b1;
      end else if (state_nxt == ST_RAM_BACKUP) begin
         pinOut_r <= 1'b0;                                             // RL17
         pinOe_r  <= ~floatPin;                                        // RL17
      end else begin
         pinOut_r <= carryOut;
         pinOe_r  <= ~floatPin;
      end
   end

   wire sleeping = (state_r == ST_CLOCK_RUN) | (state_r == ST_RAM_BACKUP);

   assign powerFlag      = pflag_r;                                    // RL11
   assign detectorActive = detEn_r;                                    // RL2
   assign armed          = arm_r;
   assign asleep         = sleeping;
   assign cpuReset       = cold_r;
   assign warmStart      = warm_r;
   assign carryPinOut    = pinOut_r;
   assign carryPinOe     = pinOe_r;

   wire sleepNext = (state_nxt == ST_CLOCK_RUN) | (state_nxt == ST_RAM_BACKUP);
   wire ramNext   = (state_nxt == ST_RAM_BACKUP);

   // Sleep entry clears CPU core state; watchdog is cleared too, so restart it first
   // Decoded from the next state so the registered controls line up with the state
   assign ctrl_nxt = '{
      cpuInit:           sleepNext | coldEvent,                        // RL12
      spLoad7:           ramNext,                                      // RL14
      mainOscStop:       sleepNext,
      subOscRun:         ~ramNext,                                     // RL7 RL8
      lcdOn:             ~ramNext,                                     // RL7 RL8
      timer3Run:         ~ramNext,                                     // RL7
      timer3Undefined:   ramNext,                                      // RL8
      timers12Undefined: sleepNext,                                    // RL15
      watchdogInit:      sleepNext,                                    // RL16
      retainRegs:        ~coldEvent                                    // RL13
   };

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_r <= CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   assign ctrl = ctrl_r;

   a_arm_needed: assert property (@(posedge clock) disable iff (rst) // RL6
      (state_r == ST_RUN && !arm_r && !coldEvent) |=> state_r != ST_CLOCK_RUN && state_r != ST_RAM_BACKUP)
      else $error("Sleep entered without arming");

   a_clock_entry: assert property (@(posedge clock) disable iff (rst) // RL4
      enterClock && !coldEvent |=> state_r == ST_CLOCK_RUN && !arm_r)
      else $error("Clock-operating entry missed");

   a_ram_entry: assert property (@(posedge clock) disable iff (rst) // RL5
      enterRam && !coldEvent |=> state_r == ST_RAM_BACKUP)
      else $error("RAM back-up entry missed");

   sequence s_warm_wake;
      (state_r == ST_WAKE) ##1 (state_r == ST_RUN);
   endsequence

   a_warm_flag: assert property (@(posedge clock) disable iff (rst) // RL9
      sleeping && (state_nxt == ST_WAKE) |=> s_warm_wake ##0 (powerFlag && warmStart))
      else $error("Warm start did not set power flag");

   a_cold_flag: assert property (@(posedge clock) disable iff (rst) // RL10
      coldEvent |=> !powerFlag && cpuReset && state_r == ST_RUN)
      else $error("Cold start did not clear power flag");

   a_ram_no_t3: assert property (@(posedge clock) disable iff (rst) // RL18
      state_r == ST_RAM_BACKUP && !sync_r.extWakeup && !coldEvent |=> state_r == ST_RAM_BACKUP)
      else $error("RAM back-up woke without external wakeup");

   a_t3_return: assert property (@(posedge clock) disable iff (rst) // RL19
      state_r == ST_CLOCK_RUN && timer3Flag && !coldEvent |=> state_r == ST_WAKE)
      else $error("Timer 3 flag did not return from sleep");

   a_det_sticky: assert property (@(posedge clock) disable iff (rst) // RL3
      detEn_r && !sync_r.resetPin |=> detEn_r)
      else $error("Detector enable dropped");

   a_pin_backup: assert property (@(posedge clock) disable iff (rst) // RL17
      state_r == ST_RAM_BACKUP |-> !carryPinOut && (carryPinOe == (counterSelect != COUNTER_INPUT_INPUT_SEL)) || $changed(counterSelect))
      else $error("Carry pin wrong in RAM back-up");

   a_brownout: assert property (@(posedge clock) disable iff (rst) // RL1
      detEn_r && sync_r.voltageLow |=> cpuReset)
      else $error("Voltage drop did not reset");

   a_ram_ctrl: assert property (@(posedge clock) disable iff (rst) // RL8
      state_r == ST_RAM_BACKUP |-> !ctrl.lcdOn && ctrl.spLoad7 && ctrl.watchdogInit)
      else $error("RAM back-up controls wrong");

   sequence s_cold_restart;
      cpuReset && !powerFlag && !arm_r && (state_r == ST_RUN);
   endsequence

   sequence s_entered_sleep;
      sleeping && !arm_r && ctrl.cpuInit && ctrl.watchdogInit;
   endsequence

   a_arm_set: assert property (@(posedge clock) disable iff (rst) // RL4 RL5
      state_r == ST_RUN && instr.sleepArm && !enterClock && !enterRam && !coldEvent |=> arm_r)
      else $error("Arming instruction not taken");

   a_arm_asleep: assert property (@(posedge clock) disable iff (rst) // RL20
      sleeping && !coldEvent |=> !arm_r)
      else $error("Arming set while asleep");

   a_cold_restart: assert property (@(posedge clock) disable iff (rst) // RL10 RL20
      coldEvent |=> s_cold_restart)
      else $error("Cold start state wrong");

   a_entry_init: assert property (@(posedge clock) disable iff (rst) // RL12 RL16 RL20
      (enterClock || enterRam) && !coldEvent |=> s_entered_sleep)
      else $error("Sleep entry did not initialize core");

   a_det_set: assert property (@(posedge clock) disable iff (rst) // RL3
      instr.detectorEnable && !sync_r.resetPin |=> detEn_r)
      else $error("Detector enable not taken");

   a_det_reset: assert property (@(posedge clock) disable iff (rst) // RL3 RL10
      sync_r.resetPin |=> !detEn_r && cpuReset)
      else $error("Reset pin did not revoke detector");

   a_sleep_brownout: assert property (@(posedge clock) disable iff (rst) // RL1 RL2
      sleeping && brownOut |=> s_cold_restart)
      else $error("Voltage drop ignored while asleep");

   a_clock_ctrl: assert property (@(posedge clock) disable iff (rst) // RL7
      state_r == ST_CLOCK_RUN |-> ctrl.subOscRun && ctrl.lcdOn && ctrl.timer3Run && !ctrl.timer3Undefined)
      else $error("Clock-operating controls wrong");

   a_core_init: assert property (@(posedge clock) disable iff (rst) // RL12 RL15
      sleeping |-> ctrl.cpuInit && ctrl.mainOscStop && ctrl.timers12Undefined)
      else $error("Core not held while asleep");

   a_run_ctrl: assert property (@(posedge clock) disable iff (rst) // RL13
      state_r == ST_RUN && !cpuReset |-> !ctrl.cpuInit && !ctrl.mainOscStop && !ctrl.watchdogInit && ctrl.retainRegs)
      else $error("Run controls wrong");

   a_sp_level: assert property (@(posedge clock) disable iff (rst) // RL14
      ctrl.spLoad7 |-> state_r == ST_RAM_BACKUP)
      else $error("Stack level forced outside RAM back-up");

   a_flag_hold: assert property (@(posedge clock) disable iff (rst) // RL11
      !coldEvent && state_nxt != ST_WAKE |=> powerFlag == $past(powerFlag))
      else $error("Power flag changed without start event");

   a_wake_run: assert property (@(posedge clock) disable iff (rst) // RL9
      state_r == ST_WAKE && !coldEvent |=> state_r == ST_RUN && warmStart)
      else $error("Warm start did not resume");

   a_warm_pulse: assert property (@(posedge clock) disable iff (rst) // RL9
      warmStart |=> !warmStart)
      else $error("Warm start pulse too long");

   a_clock_hold: assert property (@(posedge clock) disable iff (rst) // RL7
      state_r == ST_CLOCK_RUN && !clockWake && !coldEvent |=> state_r == ST_CLOCK_RUN)
      else $error("Clock-operating mode left without cause");

   a_clock_ext: assert property (@(posedge clock) disable iff (rst) // RL9 RL18
      state_r == ST_CLOCK_RUN && sync_r.extWakeup && !coldEvent |=> state_r == ST_WAKE && powerFlag)
      else $error("External wakeup missed in clock mode");

   a_ram_wake: assert property (@(posedge clock) disable iff (rst) // RL9 RL18
      state_r == ST_RAM_BACKUP && sync_r.extWakeup && !coldEvent |=> state_r == ST_WAKE && powerFlag)
      else $error("External wakeup missed in RAM back-up");

   a_pin_run: assert property (@(posedge clock) disable iff (rst) // RL17
      state_nxt != ST_RAM_BACKUP |=> carryPinOut == $past(carryOut) && carryPinOe != $past(floatPin))
      else $error("Carry pin wrong while awake");

   a_pin_enter: assert property (@(posedge clock) disable iff (rst) // RL17
      state_nxt == ST_RAM_BACKUP |=> !carryPinOut && carryPinOe != $past(floatPin))
      else $error("Carry pin wrong on RAM back-up");

   a_cold_release: assert property (@(posedge clock) disable iff (rst) // RL10
      cpuReset && !coldEvent |=> !cpuReset)
      else $error("Processor reset held too long");
endmodule : power_down_and_brownout_sequencer

//--- inc/pwr_seq_pkg.sv
// Constants and carrier types for the power-down and start-condition sequencer.
// Assumes a single 100 MHz clock domain and a CPU decoder that issues one-cycle instruction strobes.
package pwr_seq_pkg;
   localparam logic [7:0] SP_RESET_LEVEL  = 8'h07;
   localparam logic [1:0] COUNTER_INPUT_INPUT_SEL  = 2'h3;
   localparam logic       PFLAG_RESET     = 1'b0;
   localparam logic       PFLAG_WARM      = 1'b1;
   localparam int         CLOCK_MHZ       = 100;
   localparam int         WAKE_DELAY_NS   = 20;
   localparam int         WAKE_CYCLES     = ((WAKE_DELAY_NS * CLOCK_MHZ) + 999) / 1000;

   typedef enum {
      ST_RUN,
      ST_CLOCK_RUN,
      ST_RAM_BACKUP,
      ST_WAKE
   } pwr_state_t;

   // One-cycle strobes from the instruction decoder
   typedef struct packed {
      logic detectorEnable;
      logic sleepArm;
      logic clockRunSleep;
      logic ramBackupSleep;
      logic watchdogRestart;
   } instr_t;

   // Asynchronous-world events, each synchronised before use
   typedef struct packed {
      logic extWakeup;
      logic resetPin;
      logic voltageLow;
   } pins_t;

   // Domain controls towards the rest of the chip
   typedef struct packed {
      logic cpuInit;
      logic spLoad7;
      logic mainOscStop;
      logic subOscRun;
      logic lcdOn;
      logic timer3Run;
      logic timer3Undefined;
      logic timers12Undefined;
      logic watchdogInit;
      logic retainRegs;
   } ctrl_t;

   // Controls while reset is held: clocks running, core held, nothing retained yet
   localparam ctrl_t CTRL_RESET = '{
      cpuInit:           1'b1,
      spLoad7:           1'b0,
      mainOscStop:       1'b0,
      subOscRun:         1'b1,
      lcdOn:             1'b1,
      timer3Run:         1'b1,
      timer3Undefined:   1'b0,
      timers12Undefined: 1'b0,
      watchdogInit:      1'b0,
      retainRegs:        1'b0
   };
endpackage : pwr_seq_pkg

//--- verif/cpu_source_model.sv
// Behavioural CPU decoder plus wakeup and reset sources for the sequencer.
// Assumes one clock; every change lands 1 ns after a rising edge.
`timescale 1ns/1ps

module cpu_source_model (
   // Clock
   input  wire logic           clock,
   // Towards the sequencer
   output pwr_seq_pkg::instr_t instr,
   output pwr_seq_pkg::pins_t  pins,
   output logic                watchdogReset,
   output logic                timer3Flag
);
   import pwr_seq_pkg::*;

   initial begin
      instr         = '0;
      pins          = '0;
      watchdogReset = 1'b0;
      timer3Flag    = 1'b0;
   end

   // One-cycle strobe, released at the next edge
   task automatic strobe(input logic [4:0] s);
      @(posedge clock);
      #1 instr = instr_t'(s);
      @(posedge clock);
      #1 instr = '0;
   endtask : strobe

   // Watchdog restarted first, since sleep entry initializes it
   task automatic enterSleep(input logic ram);
      strobe(5'h01);
      strobe(5'h08);
      strobe(ram ? 5'h02 : 5'h04);
   endtask : enterSleep

   task automatic setSrc(input logic [2:0] p, input logic wd, input logic t3);
      @(posedge clock);
      #1 pins = pins_t'(p);
      watchdogReset = wd;
      timer3Flag = t3;
   endtask : setSrc
endmodule : cpu_source_model

//--- verif/power_down_and_brownout_sequencer_tb_top.sv
// Self-checking bench for the power-down sequencer.
// Assumes the source model drives instructions, pins, watchdog and timer 3.
`timescale 1ns/1ps

module power_down_and_brownout_sequencer_tb_top;
   import pwr_seq_pkg::*;
   logic clock, rst, carryOut, powerFlag, detectorActive, armed, asleep;
   logic cpuReset, warmStart, carryPinOut, carryPinOe, watchdogReset, timer3Flag;
   logic sawReset, sawWarm;
   logic [1:0] counterSelect;
   instr_t instr;
   pins_t  pins;
   ctrl_t  ctrl;
   int num_errors, comparisons;

   cpu_source_model u_cpu (.clock(clock), .instr(instr), .pins(pins),
      .watchdogReset(watchdogReset), .timer3Flag(timer3Flag));
   power_down_and_brownout_sequencer uut (.clock(clock), .rst(rst), .instr(instr), .pins(pins),
      .watchdogReset(watchdogReset), .timer3Flag(timer3Flag), .counterSelect(counterSelect),
      .carryOut(carryOut), .powerFlag(powerFlag), .detectorActive(detectorActive), .armed(armed),
      .asleep(asleep), .cpuReset(cpuReset), .warmStart(warmStart), .ctrl(ctrl),
      .carryPinOut(carryPinOut), .carryPinOe(carryPinOe));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Pulses are caught here so scenarios need not sample their exact cycle
   always @(posedge clock) begin
      if (cpuReset === 1'b1) sawReset <= 1'b1;
      if (warmStart === 1'b1) sawWarm <= 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   task automatic check(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic test_done;
      $display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done

   task automatic testNoArm;
      u_cpu.strobe(5'h04);
      u_cpu.strobe(5'h02);
      tick(2);
      check(asleep, 1'b0);
      carryOut = 1'b0;
      tick(2);
      check({carryPinOut, carryPinOe}, 2'h1);
      carryOut = 1'b1;
      counterSelect = 2'h3;
      tick(2);
      check({carryPinOut, carryPinOe}, 2'h2);
      counterSelect = 2'h0;
      $display("noArm done");
   endtask : testNoArm

   task automatic testClockSleep;
      sawWarm = 1'b0;
      u_cpu.enterSleep(1'b0);
      check({asleep, armed}, 2'h2);
      check({ctrl.subOscRun, ctrl.lcdOn, ctrl.timer3Run}, 3'h7);
      check({ctrl.cpuInit, ctrl.mainOscStop, ctrl.watchdogInit, ctrl.timers12Undefined}, 4'hf);
      check({ctrl.spLoad7, ctrl.timer3Undefined, ctrl.retainRegs}, 3'h1);
      u_cpu.setSrc(3'h0, 1'b0, 1'b1);
      u_cpu.setSrc(3'h0, 1'b0, 1'b0);
      tick(5);
      check({powerFlag, asleep, sawWarm}, 3'h5);
      $display("clockSleep done");
   endtask : testClockSleep

   task automatic testWatchdog;
      sawReset = 1'b0;
      u_cpu.strobe(5'h08);
      check(armed, 1'b1);
      u_cpu.setSrc(3'h0, 1'b1, 1'b0);
      u_cpu.setSrc(3'h0, 1'b0, 1'b0);
      tick(3);
      check({powerFlag, armed, sawReset}, 3'h1);
      $display("watchdog done");
   endtask : testWatchdog

   task automatic testT3Pending;
      u_cpu.setSrc(3'h0, 1'b0, 1'b1);
      u_cpu.enterSleep(1'b0);
      tick(3);
      check({asleep, powerFlag}, 2'h1);
      u_cpu.setSrc(3'h0, 1'b0, 1'b0);
      $display("t3Pending done");
   endtask : testT3Pending

   task automatic testRamSleep;
      sawWarm = 1'b0;
      u_cpu.enterSleep(1'b1);
      tick(1);
      check({ctrl.lcdOn, ctrl.spLoad7, ctrl.timer3Undefined}, 3'h3);
      check(ctrl.timers12Undefined, 1'b1);
      check({carryPinOut, carryPinOe}, 2'h1);
      counterSelect = 2'h3;
      tick(2);
      check(carryPinOe, 1'b0);
      u_cpu.setSrc(3'h0, 1'b0, 1'b1);
      tick(4);
      check(asleep, 1'b1);
      u_cpu.setSrc(3'h4, 1'b0, 1'b0);
      u_cpu.setSrc(3'h0, 1'b0, 1'b0);
      tick(6);
      check({powerFlag, asleep, sawWarm}, 3'h5);
      counterSelect = 2'h0;
      $display("ramSleep done");
   endtask : testRamSleep

   task automatic testDetector;
      sawReset = 1'b0;
      u_cpu.setSrc(3'h1, 1'b0, 1'b0);
      tick(4);
      check(sawReset, 1'b0);
      u_cpu.setSrc(3'h0, 1'b0, 1'b0);
      u_cpu.strobe(5'h10);
      u_cpu.strobe(5'h10);
      check(detectorActive, 1'b1);
      u_cpu.enterSleep(1'b1);
      check({detectorActive, asleep}, 2'h3);
      u_cpu.setSrc(3'h1, 1'b0, 1'b0);
      u_cpu.setSrc(3'h0, 1'b0, 1'b0);
      tick(3);
      check({sawReset, powerFlag, asleep}, 3'h4);
      u_cpu.setSrc(3'h2, 1'b0, 1'b0);
      u_cpu.setSrc(3'h0, 1'b0, 1'b0);
      tick(3);
      check({detectorActive, powerFlag}, 2'h0);
      $display("detector done");
   endtask : testDetector

   // System reset in mid-run is the only other way to revoke the detector
   task automatic testSysReset;
      u_cpu.strobe(5'h10);
      u_cpu.strobe(5'h08);
      check({detectorActive, armed}, 2'h3);
      rst = 1'b1;
      tick(2);
      check({detectorActive, armed, cpuReset}, 3'h1);
      rst = 1'b0;
      tick(2);
      check({cpuReset, asleep, powerFlag}, 3'h0);
      $display("sysReset done");
   endtask : testSysReset

   initial begin
      rst = 1'b1;
      carryOut = 1'b1;
      counterSelect = 2'h0;
      sawReset = 1'b0;
      sawWarm = 1'b0;
      repeat (20) @(posedge clock);
      #1 rst = 1'b0;
      testNoArm();
      testClockSleep();
      testWatchdog();
      testT3Pending();
      testRamSleep();
      testDetector();
      testSysReset();
      test_done();
   end

   // Whole run needs about 120 cycles
   initial begin
      #50000;
      num_errors++;
      test_done();
   end
endmodule : power_down_and_brownout_sequencer_tb_top
